/* File: rtl/csc_clock_synth_control.sv */
module csc_clock_synth_control (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  output logic hit_out,
  input wire logic [3:0] memory_data_pins_in,
  input wire logic [7:0] power_down_control_in,
  input wire logic [7:0] panel_display_select_in,
  input wire logic [1:0] clock_control_one_src_in,
  input wire logic external_clock_enable_n_in,
  input wire logic standby_in,
  input wire logic tv_mode_in,
  input wire logic period_end_in,
  output logic refresh_from_mclk_out,
  output logic [1:0] standby_freq_sel_out,
  output logic hsync_enable_out,
  output logic vsync_enable_out,
  output csc_pkg::csc_vr_sel_t vr_clock_sel_out,
  output logic vr_is_video_clock_out,
  output logic lcd_timing_from_vr_out,
  output csc_pkg::csc_vsrc_t video_source_out,
  output logic video_from_crystal_pin_out,
  output logic [7:0] mclk_num_out,
  output logic [5:0] mclk_den_out,
  output logic [7:0] vclk_num_out,
  output logic [5:0] vclk_den_out,
  output csc_pkg::csc_ps_t vclk_post_scaler_out,
  output logic [7:0] second_video_clock_num_out,
  output logic [5:0] second_video_clock_den_out
);
  import csc_pkg::*;

  logic [7:0] clock_control_two;
  logic [7:0] memory_clock_numerator;
  logic [7:0] memory_clock_denominator;
  logic [7:0] video_clock_numerator;
  logic [7:0] video_clock_denominator;
  logic [7:0] second_video_clock_numerator;
  logic [7:0] second_video_clock_denominator;
  logic [7:0] scratch_strap_one;
  logic [7:0] scratch_two;
  logic strap_done;
  logic [7:0] next_rdata;
  logic next_hit;
  logic sleep;
  logic vr_mode;

  csc_synth_if mif ();
  csc_synth_if vif ();
  csc_synth_if v2if ();

  // ---------------------------------------------
  // register writes
  // ---------------------------------------------
  // reset value
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clock_control_two <= RST_CC2;
    end else if (write_in && index_in == IDX_CC2) begin
      clock_control_two <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      memory_clock_numerator <= RST_MNUM;
      memory_clock_denominator <= RST_MDEN;
    end else if (write_in && index_in == IDX_MNUM) begin
      memory_clock_numerator <= wdata_in;
    end else if (write_in && index_in == IDX_MDEN) begin
      memory_clock_denominator <= wdata_in & DEN_MASK;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      video_clock_numerator <= RST_VNUM;
      video_clock_denominator <= RST_VDEN;
    end else if (write_in && index_in == IDX_VNUM) begin
      video_clock_numerator <= wdata_in;
    end else if (write_in && index_in == IDX_VDEN) begin
      video_clock_denominator <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      second_video_clock_numerator <= RST_V2NUM;
      second_video_clock_denominator <= RST_V2DEN;
    end else if (write_in && index_in == IDX_V2NUM) begin
      second_video_clock_numerator <= wdata_in;
    end else if (write_in && index_in == IDX_V2DEN) begin
      second_video_clock_denominator <= wdata_in & DEN_MASK;
    end
  end

  // ---------------------------------------------
  // scratch and strap capture
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      scratch_strap_one <= RST_SCR;
    end else if (!strap_done) begin
      scratch_strap_one[STRAP_HI:0] <= memory_data_pins_in;
    end else if (write_in && index_in == IDX_SCR1) begin
      scratch_strap_one <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (write_in && index_in == IDX_SCR2) begin
      scratch_two <= wdata_in;
    end
  end

  // ---------------------------------------------
  // register reads
  // ---------------------------------------------
  always_comb begin
    next_hit = 1'b1;
    unique case (index_in)
      IDX_CC2: next_rdata = clock_control_two;
      IDX_MNUM: next_rdata = memory_clock_numerator;
      IDX_MDEN: next_rdata = memory_clock_denominator & DEN_MASK;
      IDX_VNUM: next_rdata = video_clock_numerator;
      IDX_VDEN: next_rdata = video_clock_denominator;
      IDX_V2NUM: next_rdata = second_video_clock_numerator;
      IDX_V2DEN: next_rdata = second_video_clock_denominator & DEN_MASK;
      IDX_SCR1: next_rdata = scratch_strap_one;
      IDX_SCR2: next_rdata = scratch_two;
      default: begin
        next_rdata = RST_SCR;
        next_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_out <= RST_SCR;
      hit_out <= 1'b0;
    end else if (read_in) begin
      rdata_out <= next_rdata;
      hit_out <= next_hit;
    end
  end

  // ---------------------------------------------
  // synthesiser staging
  // ---------------------------------------------
  assign mif.num = memory_clock_numerator;
  assign mif.den = memory_clock_denominator[5:0];
  assign mif.ps = CSC_PS_DIV1;
  assign mif.load = write_in &&
    (index_in == IDX_MNUM || index_in == IDX_MDEN);
  assign vif.num = video_clock_numerator;
  assign vif.den = video_clock_denominator[5:0];
  assign vif.ps = video_clock_denominator[PS_HI:PS_LO];
  assign vif.load = write_in &&
    (index_in == IDX_VNUM || index_in == IDX_VDEN);
  assign v2if.num = second_video_clock_numerator;
  assign v2if.den = second_video_clock_denominator[5:0];
  assign v2if.ps = CSC_PS_DIV1;
  assign v2if.load = write_in &&
    (index_in == IDX_V2NUM || index_in == IDX_V2DEN);

  csc_synth_hold u_mclk (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .rst_num_in(RST_MNUM),
    .rst_den_in(RST_MDEN[5:0]),
    .period_end_in(period_end_in),
    .sif(mif.synth)
  );
  csc_synth_hold u_vclk (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .rst_num_in(RST_VNUM),
    .rst_den_in(RST_VDEN[5:0]),
    .period_end_in(period_end_in),
    .sif(vif.synth)
  );
  csc_synth_hold u_second_video_clock (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .rst_num_in(RST_V2NUM),
    .rst_den_in(RST_V2DEN[5:0]),
    .period_end_in(period_end_in),
    .sif(v2if.synth)
  );

  assign mclk_num_out = mif.act_num;
  assign mclk_den_out = mif.act_den;
  assign vclk_num_out = vif.act_num;
  assign vclk_den_out = vif.act_den;
  assign vclk_post_scaler_out = csc_ps_t'(vif.act_ps);
  assign second_video_clock_num_out = v2if.act_num;
  assign second_video_clock_den_out = v2if.act_den;

  // ---------------------------------------------
  // clock and sync selection
  // ---------------------------------------------
  assign sleep = power_down_control_in[PD_SLEEP_BIT];
  assign vr_mode = panel_display_select_in[PANEL_VR_BIT];

  assign refresh_from_mclk_out = clock_control_two[CC2_REFRESH_BIT];
  assign standby_freq_sel_out = refresh_from_mclk_out ?
    power_down_control_in[PD_FREQ_HI:PD_FREQ_LO] : 2'h0;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hsync_enable_out <= 1'b1;
      vsync_enable_out <= 1'b1;
    end else if (sleep) begin
      hsync_enable_out <= !clock_control_two[CC2_SLEEP_SYNC_BIT];
      vsync_enable_out <= 1'b0;
    end else if (standby_in) begin
      hsync_enable_out <= 1'b0;
      vsync_enable_out <= 1'b1;
    end else begin
      hsync_enable_out <= 1'b1;
      vsync_enable_out <= 1'b1;
    end
  end

  assign vr_clock_sel_out = csc_vr_sel_t'(clock_control_two[1:0]);
  assign vr_is_video_clock_out = !vr_mode;
  assign lcd_timing_from_vr_out = vr_mode;

  assign video_source_out = tv_mode_in ? CSC_VS_CRYSTAL :
    csc_vsrc_t'(clock_control_one_src_in);
  assign video_from_crystal_pin_out = external_clock_enable_n_in == 1'b0;
endmodule // csc_clock_synth_control

/* File: rtl/csc_pkg.sv */
package csc_pkg;
  // ---------------------------------------------
  // register indices
  // ---------------------------------------------
  localparam logic [7:0] IDX_CC2 = 8'h69;
  localparam logic [7:0] IDX_MNUM = 8'h6A;
  localparam logic [7:0] IDX_MDEN = 8'h6B;
  localparam logic [7:0] IDX_VNUM = 8'h6C;
  localparam logic [7:0] IDX_VDEN = 8'h6D;
  localparam logic [7:0] IDX_V2NUM = 8'h6E;
  localparam logic [7:0] IDX_V2DEN = 8'h6F;
  localparam logic [7:0] IDX_SCR1 = 8'h70;
  localparam logic [7:0] IDX_SCR2 = 8'h71;
  // ---------------------------------------------
  // reset values and denominator mask
  // ---------------------------------------------
  localparam logic [7:0] RST_CC2 = 8'h80;
  localparam logic [7:0] RST_MNUM = 8'h5A;
  localparam logic [7:0] RST_MDEN = 8'h20;
  localparam logic [7:0] RST_VNUM = 8'h5B;
  localparam logic [7:0] RST_VDEN = 8'h2E;
  localparam logic [7:0] RST_V2NUM = 8'h5A;
  localparam logic [7:0] RST_V2DEN = 8'h20;
  localparam logic [7:0] RST_SCR = 8'h00;
  localparam logic [7:0] DEN_MASK = 8'h3F;
  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int CC2_REFRESH_BIT = 3;
  localparam int CC2_SLEEP_SYNC_BIT = 2;
  localparam int PD_SLEEP_BIT = 7;
  localparam int PD_FREQ_HI = 5;
  localparam int PD_FREQ_LO = 4;
  localparam int PANEL_VR_BIT = 7;
  localparam int PS_HI = 7;
  localparam int PS_LO = 6;
  localparam int STRAP_HI = 3;
  // ---------------------------------------------
  // enumerations
  // ---------------------------------------------
  typedef enum logic [1:0] {
    CSC_VR_SECOND_VIDEO_CLOCK = 2'b00,
    CSC_VR_HALF_MCLK = 2'b01,
    CSC_VR_MCLK = 2'b10,
    CSC_VR_PROG = 2'b11
  } csc_vr_sel_t;
  typedef enum logic [1:0] {
    CSC_VS_VGA = 2'b00,
    CSC_VS_PROG = 2'b01,
    CSC_VS_RSVD = 2'b10,
    CSC_VS_CRYSTAL = 2'b11
  } csc_vsrc_t;
  typedef enum logic [1:0] {
    CSC_PS_DIV1 = 2'b00,
    CSC_PS_DIV2 = 2'b10,
    CSC_PS_DIV4 = 2'b01,
    CSC_PS_DIV8 = 2'b11
  } csc_ps_t;
endpackage

/* File: rtl/csc_synth_if.sv */
interface csc_synth_if;
  logic [7:0] num;
  logic [5:0] den;
  logic [1:0] ps;
  logic load;
  logic [7:0] act_num;
  logic [5:0] act_den;
  logic [1:0] act_ps;
  modport ctrl (output num, den, ps, load,
    input act_num, act_den, act_ps);
  modport synth (input num, den, ps, load,
    output act_num, act_den, act_ps);
endinterface

/* File: rtl/csc_synth_hold.sv */
module csc_synth_hold (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] rst_num_in,
  input wire logic [5:0] rst_den_in,
  input wire logic period_end_in,
  csc_synth_if.synth sif
);
  import csc_pkg::*;

  logic pending;
  // ---------------------------------------------
  // staged settings, applied on period boundary
  // ---------------------------------------------
  // boundary update
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pending <= 1'b0;
    end else if (sif.load) begin
      pending <= 1'b1;
    end else if (period_end_in) begin
      pending <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sif.act_num <= rst_num_in;
      sif.act_den <= rst_den_in;
      sif.act_ps <= CSC_PS_DIV1;
    end else if (pending && period_end_in) begin
      sif.act_num <= sif.num;
      sif.act_den <= sif.den;
      sif.act_ps <= sif.ps;
    end
  end
endmodule // csc_synth_hold

/* File: sim/csc_clock_synth_control_chk.sv */
module csc_clock_synth_control_chk
  import csc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic hit_out,
  input wire logic [7:0] power_down_control_in,
  input wire logic [7:0] panel_display_select_in,
  input wire logic [1:0] clock_control_one_src_in,
  input wire logic standby_in,
  input wire logic tv_mode_in,
  input wire logic period_end_in,
  input wire logic refresh_from_mclk_out,
  input wire logic [1:0] standby_freq_sel_out,
  input wire logic hsync_enable_out,
  input wire logic vsync_enable_out,
  input wire logic [1:0] vr_clock_sel_out,
  input wire logic vr_is_video_clock_out,
  input wire logic lcd_timing_from_vr_out,
  input wire logic [1:0] video_source_out,
  input wire logic [7:0] mclk_num_out,
  input wire logic [5:0] mclk_den_out,
  input wire logic [7:0] vclk_num_out,
  input wire logic [5:0] vclk_den_out,
  input wire logic [1:0] vclk_post_scaler_out,
  input wire logic [7:0] second_video_clock_num_out,
  input wire logic [5:0] second_video_clock_den_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sleep_both;
  logic cc2_wr;
  // ---------------------------------------------
  // shadow of sleep sync bit
  // ---------------------------------------------
  assign cc2_wr = write_in && index_in == IDX_CC2;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sleep_both <= 1'b0;
    end else if (cc2_wr) begin
      sleep_both <= wdata_in[CC2_SLEEP_SYNC_BIT];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  a_refresh_source: assert property (
    cc2_wr |=> refresh_from_mclk_out == $past(wdata_in[3]))
    else $error("refresh source not from written bit");
  a_standby_freq: assert property (
    standby_freq_sel_out == (refresh_from_mclk_out ?
      power_down_control_in[5:4] : 2'b00))
    else $error("standby frequency select wrong");
  a_sleep_sync: assert property (
    power_down_control_in[7] |=> !vsync_enable_out &&
      hsync_enable_out == !$past(sleep_both))
    else $error("sleep sync pattern wrong");
  a_standby_sync: assert property (
    standby_in && !power_down_control_in[7] |=>
      !hsync_enable_out && vsync_enable_out)
    else $error("standby sync pattern wrong");
  a_vr_select: assert property (
    cc2_wr |=> vr_clock_sel_out == $past(wdata_in[1:0]))
    else $error("virtual refresh select not written value");
  a_vr_mode: assert property (
    vr_is_video_clock_out == !panel_display_select_in[7] &&
      lcd_timing_from_vr_out == panel_display_select_in[7])
    else $error("virtual refresh mode outputs wrong");
  a_tv_source: assert property (
    video_source_out == (tv_mode_in ? 2'b11 : clock_control_one_src_in))
    else $error("video source code wrong");
  a_den_reserved: assert property (
    read_in && (index_in == IDX_MDEN || index_in == IDX_V2DEN) |=>
      rdata_out[7:6] == 2'b00 && hit_out)
    else $error("reserved denominator bits not zero");
  a_unmapped_read: assert property (
    read_in && (index_in < IDX_CC2 || index_in > IDX_SCR2) |=>
      rdata_out == 8'h00 && !hit_out)
    else $error("unmapped read not refused");
  a_active_hold: assert property (
    $changed({mclk_num_out, mclk_den_out, vclk_num_out, vclk_den_out,
      vclk_post_scaler_out, second_video_clock_num_out, second_video_clock_den_out}) |->
      $past(period_end_in) || $past(period_end_in, 2))
    else $error("synthesiser changed outside period boundary");
  a_reset_values: assert property (
    $fell(reset_in) |-> mclk_num_out == RST_MNUM && mclk_den_out == 6'h20 &&
      vclk_num_out == RST_VNUM && vclk_den_out == 6'h2E &&
      vclk_post_scaler_out == CSC_PS_DIV1 && second_video_clock_num_out == RST_V2NUM &&
      second_video_clock_den_out == 6'h20)
    else $error("active synthesiser values wrong after reset");
  c_cc2_write: cover property (cc2_wr);
  c_sleep: cover property (power_down_control_in[7] && sleep_both);
  c_load: cover property (period_end_in ##1 $changed(vclk_num_out));
endmodule // csc_clock_synth_control_chk

bind csc_clock_synth_control csc_clock_synth_control_chk u_chk (
  .sys_clk_in, .reset_in, .index_in, .wdata_in, .write_in, .read_in,
  .rdata_out, .hit_out, .power_down_control_in, .panel_display_select_in,
  .clock_control_one_src_in, .standby_in, .tv_mode_in, .period_end_in,
  .refresh_from_mclk_out, .standby_freq_sel_out, .hsync_enable_out,
  .vsync_enable_out, .vr_clock_sel_out, .vr_is_video_clock_out,
  .lcd_timing_from_vr_out, .video_source_out, .mclk_num_out, .mclk_den_out,
  .vclk_num_out, .vclk_den_out, .vclk_post_scaler_out, .second_video_clock_num_out,
  .second_video_clock_den_out
);

/* File: sim/test_clock_synth_control.sv */
module test_clock_synth_control;
  timeunit 1ns;
  timeprecision 100ps;
  import csc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] index_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [3:0] memory_data_pins_in = 4'hA;
  logic [7:0] power_down_control_in = 8'h00;
  logic [7:0] panel_display_select_in = 8'h00;
  logic [1:0] clock_control_one_src_in = 2'b00;
  logic external_clock_enable_n_in = 1'b1;
  logic standby_in = 1'b0;
  logic tv_mode_in = 1'b0;
  logic period_end_in = 1'b0;
  logic [7:0] rdata_out, mclk_num_out, vclk_num_out, second_video_clock_num_out;
  logic hit_out, refresh_from_mclk_out, hsync_enable_out, vsync_enable_out;
  logic vr_is_video_clock_out, lcd_timing_from_vr_out;
  logic video_from_crystal_pin_out;
  logic [1:0] standby_freq_sel_out;
  logic [5:0] mclk_den_out, vclk_den_out, second_video_clock_den_out;
  csc_vr_sel_t vr_clock_sel_out;
  csc_vsrc_t video_source_out;
  csc_ps_t vclk_post_scaler_out;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] rst_val [7] = '{RST_CC2, RST_MNUM, RST_MDEN, RST_VNUM,
    RST_VDEN, RST_V2NUM, RST_V2DEN};
  logic [7:0] pat [2] = '{8'hC3, 8'h3C};

  csc_clock_synth_control DUT (
    .sys_clk_in, .reset_in, .index_in, .wdata_in, .write_in, .read_in,
    .rdata_out, .hit_out, .memory_data_pins_in, .power_down_control_in,
    .panel_display_select_in, .clock_control_one_src_in,
    .external_clock_enable_n_in, .standby_in, .tv_mode_in, .period_end_in,
    .refresh_from_mclk_out, .standby_freq_sel_out, .hsync_enable_out,
    .vsync_enable_out, .vr_clock_sel_out, .vr_is_video_clock_out,
    .lcd_timing_from_vr_out, .video_source_out, .video_from_crystal_pin_out,
    .mclk_num_out, .mclk_den_out, .vclk_num_out, .vclk_den_out,
    .vclk_post_scaler_out, .second_video_clock_num_out, .second_video_clock_den_out
  );

  always #12.5 sys_clk_in = ~sys_clk_in;

  // ---------------------------------------------
  // access tasks
  // ---------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic bus(input logic [7:0] idx, dat, input logic w, r, pe);
    tick(1);
    {index_in, wdata_in, write_in, read_in, period_end_in} =
      {idx, dat, w, r, pe};
    tick(1);
    {write_in, read_in, period_end_in} = 3'b000;
  endtask
  task automatic rd(input logic [7:0] idx, exp, input logic hit);
    bus(idx, 8'h00, 1'b0, 1'b1, 1'b0);
    chk("rdata", rdata_out, exp);
    chk("hit", {7'h0, hit_out}, {7'h0, hit});
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    conclude;
  end

  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    tick(2);
    reset_in = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'h69 + i[7:0], rst_val[i], 1'b1);
    end
    rd(IDX_SCR1, 8'h0A, 1'b1);
    bus(8'h72, 8'hFF, 1'b1, 1'b0, 1'b0);
    rd(8'h72, 8'h00, 1'b0);
    foreach (pat[p]) begin
      for (int i = 0; i < 9; i++) begin
        bus(8'h69 + i[7:0], pat[p], 1'b1, 1'b0, 1'b0);
        rd(8'h69 + i[7:0], pat[p] & ((i == 2 || i == 6) ? 8'h3F : 8'hFF),
          1'b1);
      end
    end
    power_down_control_in = 8'h20;
    for (int c = 0; c < 4; c++) begin
      bus(IDX_CC2, {4'h0, c[0], 1'b0, c[1:0]}, 1'b1, 1'b0, 1'b0);
      chk("vr_sel", {6'h0, vr_clock_sel_out}, {6'h0, c[1:0]});
      chk("refresh", {7'h0, refresh_from_mclk_out}, {7'h0, c[0]});
      chk("sb_freq", {6'h0, standby_freq_sel_out}, c[0] ? 8'h02 : 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      bus(IDX_CC2, {5'h0, m == 1, 2'b00}, 1'b1, 1'b0, 1'b0);
      power_down_control_in = {m < 2, 7'h00};
      standby_in = m == 2;
      tick(2);
      chk("hsync", {7'h0, hsync_enable_out},
        {7'h0, m == 0 || m == 3});
      chk("vsync", {7'h0, vsync_enable_out}, {7'h0, m > 1});
    end
    for (int s = 0; s < 8; s++) begin
      clock_control_one_src_in = s[1:0];
      tv_mode_in = s[2];
      external_clock_enable_n_in = s[0];
      panel_display_select_in = {s[1], 7'h00};
      tick(1);
      chk("vsrc", {6'h0, video_source_out},
        s[2] ? 8'h03 : {6'h0, s[1:0]});
      chk("xtal", {7'h0, video_from_crystal_pin_out}, {7'h0, !s[0]});
      chk("vr_vid", {7'h0, vr_is_video_clock_out}, {7'h0, !s[1]});
      chk("lcd_vr", {7'h0, lcd_timing_from_vr_out}, {7'h0, s[1]});
    end
    bus(IDX_MNUM, 8'h33, 1'b1, 1'b0, 1'b1);
    tick(2);
    chk("mnum_old", mclk_num_out, 8'h3C);
    bus(8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
    tick(2);
    chk("mnum_new", mclk_num_out, 8'h33);
    chk("v2den", {2'b00, second_video_clock_den_out}, 8'h3C);
    for (int c = 0; c < 4; c++) begin
      bus(IDX_VDEN, {c[1:0], (c == 0) ? 6'h0A : 6'h05}, 1'b1, 1'b0,
        1'b0);
      bus(8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
      tick(2);
      chk("ps", {6'h0, vclk_post_scaler_out}, {6'h0, c[1:0]});
      chk("vden", {2'b00, vclk_den_out}, (c == 0) ? 8'h0A : 8'h05);
    end
    memory_data_pins_in = 4'h5;
    reset_in = 1'b1;
    tick(2);
    reset_in = 1'b0;
    rd(IDX_CC2, RST_CC2, 1'b1);
    rd(IDX_SCR1, 8'h05, 1'b1);
    conclude;
  end
endmodule // test_clock_synth_control
